//--- hw/gcis_map.svh
// Register offsets, routing entry layout and timing codes of the GCI/SCIT interface
`ifndef GCIS_MAP_SVH
`define GCIS_MAP_SVH
`define GCIS_ADR_MODE 9'h000
`define GCIS_ADR_GMR 9'h001
`define GCIS_ADR_STAT 9'h002
`define GCIS_ADR_RAM_BIT 10
`define GCIS_MODE_DSC 0
`define GCIS_MODE_STZ 1
`define GCIS_MODE_CRT 2
`define GCIS_MODE_GR_LO 4
`define GCIS_GMR_EN 2
`define GCIS_E_LST 0
`define GCIS_E_BYT 2
`define GCIS_E_CNT_HI 6
`define GCIS_E_CNT_LO 3
`define GCIS_E_CHANNEL_SELECT_CODE_HI 9
`define GCIS_E_CHANNEL_SELECT_CODE_LO 7
`define GCIS_CHANNEL_SELECT_CODE_NONE 3'h0
`define GCIS_CHANNEL_SELECT_CODE_GRANT 3'h7
`define GCIS_BYTE_LEN 8'h08
`define GCIS_SEC_RX 0
`define GCIS_SEC_TX 1
`define GCIS_PIN_RCLK 0
`define GCIS_PIN_RSYNC 1
`define GCIS_PIN_RDATA 2
`define GCIS_PIN_TCLK 3
`define GCIS_PIN_TSYNC 4
`endif

//--- hw/gcis_pkg.sv
// Types of the GCI/SCIT interface
package gcis_pkg;
    typedef enum logic [1:0] {GCIS_HUNT = 2'h0, GCIS_RUN = 2'h1, GCIS_DONE = 2'h3} gcis_state_e;
    typedef struct packed {
        logic wb_ack;
        logic [31:0] wb_dat;
        logic en;
        logic [7:0] mode;
        logic [4:0] pin_m;
        logic [4:0] pin_s;
        logic [4:0] pin_p;
        logic dclk;
        logic [1:0] phase;
        gcis_state_e [1:0] st;
        logic [1:0][6:0] ptr;
        logic [1:0][7:0] bcnt;
        logic rx_bit;
        logic [6:1] rx_stb;
        logic [6:1] tx_take;
        logic gbit;
        logic [3:0] grant;
        logic [3:0] abort;
        logic tx_oe;
        logic tx_o;
    } gcis_state_s;
endpackage

//--- hw/gcis_tdm.sv
// GCI/SCIT time-slot routing interface with Wishbone register access
// How it works
// - Data clock is line clock halved when double speed is set, else a copy.
// - Frame holds B1, B2, monitor, signalling and command/indication channels.
// - Capture only enabled bits; drive transmit line only in enabled bits.
// - Check the grant-marked bit before sending signalling data.
// - Grant bit high on collision; abort and resend when set again.
// - Automatic abort applies only during the first two buffers.
// - Channel 0 indication reaches the management controller, which interrupts.
// - Force-zero bit holds transmitted data at zero.
// - Frame on the GCI sync pulse, data clock at half line rate when double speed is set.
// - Timing link bit feeds receive clock and sync to transmit section.
// - Grant route clear means no grant check; set passes the inverted sampled grant bit.
// - Code 111 entry raises no receive strobe and samples its bit as grant.
// - Table ends at the entry with the last-entry flag.
// - Sync while the table runs is ignored; resync on the next one.
`timescale 1ns/1ps
`include "gcis_map.svh"
module gcis_tdm (
    input wire logic clock, // System clock 25 MHz
    input wire logic rst, // Synchronous reset
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Bus strobe
    input wire logic wb_we_i, // Bus write
    input wire logic [10:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic line_rx_clock, // Line clock pin
    input wire logic line_rx_sync, // Line sync pin
    input wire logic line_rx_data, // Line receive data pin
    input wire logic line_tx_clock, // Separate transmit clock pin
    input wire logic line_tx_sync, // Separate transmit sync pin
    output logic line_tx_data_o, // Open-drain data, always low
    output logic line_tx_data_oe, // Drives the line low when high
    output logic data_clock_out, // Data clock output
    input wire logic [6:1] tx_data_in, // Next bit per controller
    input wire logic [3:0] tx_first_two, // Serial controller sends buffer 1 or 2
    output logic rx_bit, // Received bit
    output logic [6:1] rx_strobe, // Received bit valid per controller
    output logic [6:1] tx_take, // Transmit bit taken per controller
    output logic [3:0] grant_out, // Grant per serial controller
    output logic [3:0] abort_out // Collision abort pulse
);
    gcis_pkg::gcis_state_s q, d;
    logic [15:0] ram [0:255];
    logic ram_hit;
    logic [7:0] ram_idx;
    logic [1:0] tick;
    logic [1:0] sync;
    logic [1:0][7:0] len;
    logic [1:0][2:0] channel_select_code;
    logic [1:0][15:0] ent;

    // ************************************************************
    // Entry decode
    // ************************************************************
    function automatic logic [7:0] entry_len(input logic [15:0] w);
        logic [7:0] n;
        n = {4'h0, w[`GCIS_E_CNT_HI:`GCIS_E_CNT_LO]} + 8'h01;
        entry_len = w[`GCIS_E_BYT] ? 8'(n * `GCIS_BYTE_LEN) : n;
    endfunction

    function automatic logic [2:0] entry_channel_select_code(input logic [15:0] w);
        entry_channel_select_code = w[`GCIS_E_CHANNEL_SELECT_CODE_HI:`GCIS_E_CHANNEL_SELECT_CODE_LO];
    endfunction

    assign ram_hit = wb_adr_i[`GCIS_ADR_RAM_BIT];
    assign ram_idx = wb_adr_i[9:2];

    // ************************************************************
    // Routing RAM
    // ************************************************************
    always_ff @(posedge clock)
    begin
        if (wb_cyc_i && wb_stb_i && wb_we_i && q.wb_ack && ram_hit)
        begin
            if (wb_sel_i[0])
            begin
                ram[ram_idx][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1])
            begin
                ram[ram_idx][15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        logic [1:0] clk_sel;
        logic [1:0] sync_sel;
        logic [1:0] rise;
        logic [6:0] idx;
        logic [7:0] bc;
        d = q;
        clk_sel = '0;
        sync_sel = '0;
        rise = '0;
        idx = '0;
        bc = '0;
        tick = '0;
        sync = '0;
        len = '0;
        channel_select_code = '0;
        ent = '0;
        d.wb_ack = 1'b0;
        d.rx_stb = '0;
        d.tx_take = '0;
        d.abort = '0;
        d.tx_o = 1'b0;
        d.pin_m = {line_tx_sync, line_tx_clock, line_rx_data, line_rx_sync, line_rx_clock};
        d.pin_s = q.pin_m;
        d.pin_p = q.pin_s;
        // Bus slave: one wait cycle, defined answer everywhere
        if (wb_cyc_i && wb_stb_i && !q.wb_ack)
        begin
            d.wb_ack = 1'b1;
            if (ram_hit)
            begin
                d.wb_dat = {16'h0000, ram[ram_idx]};
            end
            else if (wb_adr_i[10:2] == `GCIS_ADR_MODE)
            begin
                d.wb_dat = {24'h000000, q.mode};
            end
            else if (wb_adr_i[10:2] == `GCIS_ADR_GMR)
            begin
                d.wb_dat = 32'({q.en, 2'h0});
            end
            else if (wb_adr_i[10:2] == `GCIS_ADR_STAT)
            begin
                d.wb_dat = {7'h00, q.gbit, q.grant, q.st, 1'b0, q.ptr[1], 1'b0, q.ptr[0]};
            end
            else
            begin
                d.wb_dat = '0;
            end
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && q.wb_ack && !ram_hit && wb_sel_i[0])
        begin
            if (wb_adr_i[10:2] == `GCIS_ADR_MODE)
            begin
                d.mode = wb_dat_i[7:0];
            end
            else if (wb_adr_i[10:2] == `GCIS_ADR_GMR)
            begin
                d.en = wb_dat_i[`GCIS_GMR_EN];
            end
        end
        // Section timing: transmit may borrow receive clock and sync
        clk_sel[`GCIS_SEC_RX] = q.pin_s[`GCIS_PIN_RCLK];
        sync_sel[`GCIS_SEC_RX] = q.pin_s[`GCIS_PIN_RSYNC];
        rise[`GCIS_SEC_RX] = q.pin_s[`GCIS_PIN_RCLK] && !q.pin_p[`GCIS_PIN_RCLK];
        if (q.mode[`GCIS_MODE_CRT])
        begin
            clk_sel[`GCIS_SEC_TX] = clk_sel[`GCIS_SEC_RX];
            sync_sel[`GCIS_SEC_TX] = sync_sel[`GCIS_SEC_RX];
            rise[`GCIS_SEC_TX] = rise[`GCIS_SEC_RX];
        end
        else
        begin
            clk_sel[`GCIS_SEC_TX] = q.pin_s[`GCIS_PIN_TCLK];
            sync_sel[`GCIS_SEC_TX] = q.pin_s[`GCIS_PIN_TSYNC];
            rise[`GCIS_SEC_TX] = q.pin_s[`GCIS_PIN_TCLK] && !q.pin_p[`GCIS_PIN_TCLK];
        end
        // Data clock out
        if (q.mode[`GCIS_MODE_DSC])
        begin
            if (rise[`GCIS_SEC_RX])
            begin
                d.dclk = !q.dclk;
            end
        end
        else
        begin
            d.dclk = clk_sel[`GCIS_SEC_RX];
        end
        for (int s = 0; s < 2; s++)
        begin
            sync[s] = sync_sel[s];
            // Bit tick, half rate when double speed is set, realigned by sync
            if (rise[s])
            begin
                tick[s] = !q.mode[`GCIS_MODE_DSC] || q.phase[s] || sync_sel[s];
                d.phase[s] = !tick[s];
            end
            idx = (q.st[s] == gcis_pkg::GCIS_RUN) ? q.ptr[s] : 7'h00;
            bc = (q.st[s] == gcis_pkg::GCIS_RUN) ? q.bcnt[s] : 8'h00;
            ent[s] = ram[{s[0], idx}];
            len[s] = entry_len(ent[s]);
            channel_select_code[s] = entry_channel_select_code(ent[s]);
            if (!q.en)
            begin
                d.st[s] = gcis_pkg::GCIS_HUNT;
            end
            else if (tick[s] && (q.st[s] == gcis_pkg::GCIS_RUN || sync_sel[s]))
            begin
                d.st[s] = gcis_pkg::GCIS_RUN;
                if (bc == len[s] - 8'h01)
                begin
                    d.bcnt[s] = 8'h00;
                    if (ent[s][`GCIS_E_LST])
                    begin
                        d.st[s] = gcis_pkg::GCIS_DONE;
                    end
                    else
                    begin
                        d.ptr[s] = idx + 7'h01;
                    end
                end
                else
                begin
                    d.ptr[s] = idx;
                    d.bcnt[s] = bc + 8'h01;
                end
                if (s == `GCIS_SEC_RX)
                begin
                    if (channel_select_code[s] == `GCIS_CHANNEL_SELECT_CODE_GRANT)
                    begin
                        d.gbit = q.pin_s[`GCIS_PIN_RDATA];
                        for (int i = 0; i < 4; i++)
                        begin
                            d.grant[i] = q.mode[`GCIS_MODE_GR_LO + i] ?
                                !q.pin_s[`GCIS_PIN_RDATA] : 1'b1;
                            d.abort[i] = q.mode[`GCIS_MODE_GR_LO + i] && tx_first_two[i] &&
                                q.pin_s[`GCIS_PIN_RDATA];
                        end
                    end
                    else if (channel_select_code[s] != `GCIS_CHANNEL_SELECT_CODE_NONE)
                    begin
                        d.rx_bit = q.pin_s[`GCIS_PIN_RDATA];
                        d.rx_stb[channel_select_code[s]] = 1'b1;
                    end
                end
                else
                begin
                    d.tx_oe = 1'b0;
                    if (channel_select_code[s] != `GCIS_CHANNEL_SELECT_CODE_NONE && channel_select_code[s] != `GCIS_CHANNEL_SELECT_CODE_GRANT)
                    begin
                        d.tx_take[channel_select_code[s]] = 1'b1;
                        d.tx_oe = q.mode[`GCIS_MODE_STZ] || !tx_data_in[channel_select_code[s]];
                    end
                end
            end
            else if (tick[s] && s == `GCIS_SEC_TX)
            begin
                d.tx_oe = 1'b0;
            end
        end
        if (!q.en)
        begin
            d.tx_oe = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.wb_ack;
    assign line_tx_data_o = q.tx_o;
    assign line_tx_data_oe = q.tx_oe;
    assign data_clock_out = q.dclk;
    assign rx_bit = q.rx_bit;
    assign rx_strobe = q.rx_stb;
    assign tx_take = q.tx_take;
    assign grant_out = q.grant;
    assign abort_out = q.abort;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_tx_tick_run;
        tick[`GCIS_SEC_TX] && q.en && q.st[`GCIS_SEC_TX] == gcis_pkg::GCIS_RUN;
    endsequence

    sequence s_rx_tick_run;
        tick[`GCIS_SEC_RX] && q.en && q.st[`GCIS_SEC_RX] == gcis_pkg::GCIS_RUN;
    endsequence

    a_clk_copy: assert property (@(posedge clock) disable iff (rst)
        !q.mode[`GCIS_MODE_DSC] && !d.mode[`GCIS_MODE_DSC] |=>
        data_clock_out == $past(q.pin_s[`GCIS_PIN_RCLK]))
        else $error("data clock is not a copy of line clock");

    a_clk_half: assert property (@(posedge clock) disable iff (rst)
        q.mode[`GCIS_MODE_DSC] && q.pin_s[`GCIS_PIN_RCLK] && !q.pin_p[`GCIS_PIN_RCLK] |=>
        data_clock_out != $past(data_clock_out))
        else $error("data clock did not toggle on line clock rise");

    a_tx_undriven: assert property (@(posedge clock) disable iff (rst)
        s_tx_tick_run ##0 (channel_select_code[`GCIS_SEC_TX] == `GCIS_CHANNEL_SELECT_CODE_NONE) |=> !line_tx_data_oe)
        else $error("transmit line driven in disabled bit");

    a_stz_zero: assert property (@(posedge clock) disable iff (rst)
        s_tx_tick_run ##0 (q.mode[`GCIS_MODE_STZ] && channel_select_code[`GCIS_SEC_TX] != `GCIS_CHANNEL_SELECT_CODE_NONE &&
        channel_select_code[`GCIS_SEC_TX] != `GCIS_CHANNEL_SELECT_CODE_GRANT) |=> line_tx_data_oe && !line_tx_data_o)
        else $error("force zero did not drive zero");

    a_grant_free: assert property (@(posedge clock) disable iff (rst)
        !q.mode[`GCIS_MODE_GR_LO] && $past(!q.mode[`GCIS_MODE_GR_LO]) &&
        $past(grant_out[0]) |-> grant_out[0])
        else $error("grant dropped without grant routing");

    a_grant_strobe: assert property (@(posedge clock) disable iff (rst)
        s_rx_tick_run ##0 (channel_select_code[`GCIS_SEC_RX] == `GCIS_CHANNEL_SELECT_CODE_GRANT) |=>
        q.gbit == $past(q.pin_s[`GCIS_PIN_RDATA]) && rx_strobe == 6'h00)
        else $error("grant bit not sampled");

    a_abort_gate: assert property (@(posedge clock) disable iff (rst)
        abort_out[0] |-> $past(tx_first_two[0]) && $past(q.mode[`GCIS_MODE_GR_LO]))
        else $error("abort outside first two buffers");

    a_sync_ignore: assert property (@(posedge clock) disable iff (rst)
        s_rx_tick_run ##0 (sync[`GCIS_SEC_RX] && q.ptr[`GCIS_SEC_RX] != 7'h00 &&
        !ent[`GCIS_SEC_RX][`GCIS_E_LST]) |=> q.ptr[`GCIS_SEC_RX] != 7'h00)
        else $error("mid-frame sync restarted the table");

    a_last_stop: assert property (@(posedge clock) disable iff (rst)
        s_rx_tick_run ##0 (ent[`GCIS_SEC_RX][`GCIS_E_LST] &&
        q.bcnt[`GCIS_SEC_RX] == len[`GCIS_SEC_RX] - 8'h01) |=>
        q.st[`GCIS_SEC_RX] == gcis_pkg::GCIS_DONE)
        else $error("table did not end at last entry");

    a_wrap_first: assert property (@(posedge clock) disable iff (rst)
        q.en && tick[`GCIS_SEC_RX] && sync[`GCIS_SEC_RX] &&
        q.st[`GCIS_SEC_RX] == gcis_pkg::GCIS_DONE |=>
        q.st[`GCIS_SEC_RX] == gcis_pkg::GCIS_RUN)
        else $error("frame did not restart on sync");
endmodule

//--- test/gcis_l1_model.sv
// Layer 1 transceiver model on the line side
`timescale 1ns/1ps
module gcis_l1_model (
    input wire logic clock, // System clock
    input wire logic rst, // Reset
    input wire logic active, // Link activated
    input wire logic xs, // Stray sync at bit 2, inside the table
    input wire logic [95:0] fbits, // Frame content
    input wire logic oe, // Device pulls line low
    output logic lclk, // Line clock
    output logic lsync, // Frame sync
    output logic ldata, // Line data
    output logic fstart, // Bit 0 clock edge
    output logic [6:0] lows // Low bits of last frame
);
    logic [3:0] ph;
    logic [6:0] bi;
    logic [6:0] nb;
    logic [6:0] acc;
    logic lvl;
    assign lvl = oe ? 1'b0 : 1'b1;
    assign nb = (bi == 7'h5F) ? 7'h00 : bi + 7'h01;
    always @(posedge clock)
    begin
        fstart <= 1'b0;
        if (rst || !active)
        begin
            ph <= 4'h0;
            bi <= 7'h00;
            acc <= 7'h00;
            lclk <= 1'b0;
            ldata <= 1'b1;
            lsync <= 1'b0;
        end
        else
        begin
            ph <= ph + 4'h1;
            if (ph == 4'h7)
            begin
                lclk <= 1'b0;
                bi <= nb;
                ldata <= fbits[nb];
                lsync <= (nb == 7'h00) || (xs && nb == 7'h02);
            end
            if (ph == 4'hB)
            begin
                acc <= (bi == 7'h5F) ? 7'h00 : acc + {6'h00, !lvl};
                if (bi == 7'h5F)
                    lows <= acc + {6'h00, !lvl};
            end
            if (ph == 4'hF)
            begin
                lclk <= 1'b1;
                fstart <= (bi == 7'h00);
            end
        end
    end
endmodule

//--- test/gcis_tdm_tb_top.sv
// Self-checking bench of the GCI/SCIT routing interface
`timescale 1ns/1ps
module gcis_tdm_tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [10:0] wb_adr_i = 11'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic wb_ack_o, lclk, lsync, ldata, fstart, oe, tx_o, dclk, rx_bit;
    logic [6:0] lows;
    logic [6:1] rx_strobe, tx_take;
    logic [6:1] tx_data_in = 6'h00;
    logic [3:0] tx_first_two = 4'h0;
    logic [3:0] grant_out, abort_out;
    logic active = 1'b0, xs = 1'b0, txp = 1'b0, clr = 1'b0, dclk_q = 1'b0;
    logic [95:0] fbits = 96'h0;
    logic [15:0] rxg [7];
    logic [31:0] tab [4];
    logic [31:0] seed = 32'h6EF4;
    localparam logic [2:0] mgmt_code = 3'h5; // Management controller for C/I
    int rxn [7];
    int take_n [7];
    int abort_n [4];
    int dclk_n;
    int num_errors = 0;
    int cmp_count = 0;
    always #20 clock = ~clock;
    gcis_l1_model i_l1 (.clock(clock), .rst(rst), .active(active), .xs(xs), .fbits(fbits),
        .oe(oe), .lclk(lclk), .lsync(lsync), .ldata(ldata), .fstart(fstart), .lows(lows));
    gcis_tdm i_dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_rx_clock(lclk), .line_rx_sync(lsync),
        .line_rx_data(ldata), .line_tx_clock(lclk & txp), .line_tx_sync(lsync & txp),
        .line_tx_data_o(tx_o), .line_tx_data_oe(oe), .data_clock_out(dclk),
        .tx_data_in(tx_data_in), .tx_first_two(tx_first_two), .rx_bit(rx_bit),
        .rx_strobe(rx_strobe), .tx_take(tx_take), .grant_out(grant_out), .abort_out(abort_out));
    always @(posedge clock)
    begin
        dclk_q <= dclk;
        if (clr)
        begin
            dclk_n <= 0;
            rxn <= '{default: 0};
            take_n <= '{default: 0};
            abort_n <= '{default: 0};
        end
        else
        begin
            dclk_n <= dclk_n + int'(dclk && !dclk_q);
            for (int c = 1; c < 7; c++)
            begin
                if (rx_strobe[c])
                    rxg[c][rxn[c]] <= rx_bit;
                rxn[c] <= rxn[c] + int'(rx_strobe[c]);
                take_n[c] <= take_n[c] + int'(tx_take[c]);
            end
            for (int c = 0; c < 4; c++)
                abort_n[c] <= abort_n[c] + int'(abort_out[c]);
        end
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ent(input logic [2:0] cs, input logic [3:0] cn,
        input logic by, input logic ls);
        return {22'h0, cs, cn, by, 1'b0, ls};
    endfunction
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Classic Wishbone single cycle, waits for ack
    task automatic wb(input logic we, input logic [10:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clock);
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clock);
            n++;
        end
        q = wb_dat_o;
        chk_val("ack wait", 32'h1, 32'(n < 50));
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clock);
    endtask
    // One frame: set up, clear, run, compare with model
    task automatic frame(input logic [7:0] md, input logic p, input logic x);
        logic [95:0] f;
        logic [6:1] d;
        logic [3:0] ft;
        logic [15:0] e1, e2;
        int s, lo;
        f = {rnd(), rnd(), rnd()};
        d = 6'(rnd());
        ft = 4'(rnd());
        s = md[0] ? 2 : 1;
        @(posedge clock iff fstart === 1'b1);
        // Retune only once both tables are done and the line is released
        repeat (800) @(posedge clock);
        wb(1'b1, 11'h000, {24'h0, md});
        wb(1'b0, 11'h000, 32'h0);
        chk_val("mode", {24'h0, md}, q);
        fbits <= f;
        tx_data_in <= d;
        tx_first_two <= ft;
        txp <= p;
        xs <= x;
        @(posedge clock iff fstart === 1'b1);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        @(posedge clock iff fstart === 1'b1);
        lo = 2 * int'(!d[1]) + 8 * int'(!d[mgmt_code]);
        if (md[1])
            lo = 10;
        if (!(md[2] || p))
            lo = 0;
        for (int j = 0; j < 16; j++)
        begin
            e1[j] = f[s * j];
            e2[j] = f[s * (j + 3)];
        end
        chk_val("rx1 n", 32'h2, 32'(rxn[1]));
        chk_val("rx1", {30'h0, e1[1:0]}, {30'h0, rxg[1][1:0]});
        chk_val("rx2 n", 32'h8, 32'(rxn[mgmt_code]));
        chk_val("rx2", {24'h0, e2[7:0]}, {24'h0, rxg[mgmt_code][7:0]});
        chk_val("rx other", 32'h0, 32'(rxn[2] + rxn[3] + rxn[4] + rxn[6]));
        chk_val("tx lows", 32'(s * lo), {25'h0, lows});
        chk_val("tx o", 32'h0, {31'h0, tx_o});
        chk_val("dclk", 32'(96 / s), 32'(dclk_n));
        if (!md[1])
            chk_val("takes", (md[2] || p) ? 32'hA : 32'h0,
                32'(take_n[1] + take_n[mgmt_code]));
        for (int i = 0; i < 4; i++)
        begin
            chk_val("grant", {31'h0, md[4 + i] ? !f[2 * s] : 1'b1}, {31'h0, grant_out[i]});
            chk_val("abort", 32'(md[4 + i] && f[2 * s] && ft[i]), 32'(abort_n[i]));
        end
        wb(1'b0, 11'h008, 32'h0);
        chk_val("grant bit", {31'h0, f[2 * s]}, {31'h0, q[24]});
    endtask
    initial
    begin
        tab = '{ent(3'h1, 4'h1, 1'b0, 1'b0), ent(3'h7, 4'h0, 1'b0, 1'b0),
            ent(mgmt_code, 4'h0, 1'b1, 1'b1), 32'h1};
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, 11'h400 + 11'(4 * i), tab[i]);
            wb(1'b1, 11'h600 + 11'(4 * i), (i == 1) ? 32'h0 : tab[i]);
        end
        wb(1'b0, 11'h408, 32'h0);
        chk_val("ram", tab[2], q);
        wb(1'b0, 11'h00C, 32'h0);
        chk_val("unmapped", 32'h0, q);
        wb(1'b1, 11'h004, 32'h4);
        active <= 1'b1;
        frame(8'h14, 1'b0, 1'b0);
        frame(8'h04, 1'b0, 1'b1);
        frame(8'h16, 1'b0, 1'b0);
        frame(8'h15, 1'b0, 1'b0);
        frame(8'h10, 1'b0, 1'b0);
        frame(8'h30, 1'b1, 1'b0);
        frame(8'hF4, 1'b1, 1'b1);
        finish_test();
    end
    initial
    begin
        #2400000;
        num_errors++;
        finish_test();
    end
endmodule
